/* rtl/pta_map.vh */
// Register offsets, reset values, oscillator mode codes and field positions for the port block
`ifndef PTA_MAP_VH
`define PTA_MAP_VH
`define PTA_OFS_PINS 5'h00
`define PTA_OFS_LATCH 5'h04
`define PTA_OFS_DIR 5'h08
`define PTA_OFS_ANS_LO 5'h0c
`define PTA_OFS_ANS_HI 5'h10
`define PTA_OFS_OSC_MODE 5'h14
`define PTA_RST_LATCH 8'h00
`define PTA_RST_DIR 8'hff
`define PTA_RST_ANS_LO 8'h3f
`define PTA_RST_ANS_HI 1'h1
`define PTA_RST_OSC 3'h0
`define PTA_ANS_LO_MASK_SMALL 8'h1f
// Oscillator mode codes
`define PTA_OSC_CRYSTAL 3'h0
`define PTA_OSC_RC_CLKOUT 3'h1
`define PTA_OSC_RC_IO 3'h2
`define PTA_OSC_INT_CLKOUT 3'h3
`define PTA_OSC_INT_IO 3'h4
`define PTA_OSC_EXT_CLKOUT 3'h5
`define PTA_OSC_EXT_IO 3'h6
`define PTA_OSC_EXT_OSC 3'h7
`define PTA_BIT6 6
`define PTA_BIT7 7
`define PTA_CYC_DIV_MAX 2'h3
`define PTA_CYC_HALF 2'h2
`endif

/* rtl/pta_cyc_div.v */
// Divider producing the instruction cycle clock, one quarter of the core clock
`timescale 1ns/10ps
`include "pta_map.vh"
module pta_cyc_div (
    input wire hclk,
    input wire hresetn,
    output reg cyc_clk_q
);
    reg [1:0] cnt_q;

    // Count four core cycles; high for two, low for two
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 2'h0;
            cyc_clk_q <= 1'b0;
        end else begin
            cnt_q <= (cnt_q == `PTA_CYC_DIV_MAX) ? 2'h0 : cnt_q + 2'h1;
            cyc_clk_q <= (cnt_q == `PTA_CYC_DIV_MAX) || (cnt_q < `PTA_CYC_HALF - 2'h1);
        end
    end
endmodule // pta_cyc_div

/* rtl/pta_top.v */
// Eight-bit general purpose port with analog select and oscillator pin gating
`timescale 1ns/10ps
`include "pta_map.vh"
module pta_top #(
    parameter LARGE_PKG = 1
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    input wire [7:0] pin_in,
    output reg [7:0] pin_out,
    output reg [7:0] pin_oe,
    output wire [7:0] analog_en,
    output wire [2:0] capture_in,
    output wire encoder_index_input,
    output wire encoder_channel_a,
    output wire encoder_channel_b,
    output wire [2:0] osc_mode
);
    reg [7:0] port_output_latch_q;
    reg [7:0] port_direction_q;
    reg [7:0] analog_select_low_q;
    reg analog_select_high_q;
    reg [2:0] osc_mode_q;
    reg wr_pend_q;
    reg rd_pend_q;
    reg [4:0] addr_q;
    wire cyc_clk;
    wire [7:0] ans_mask;
    wire [7:0] ans_pin;
    wire [7:0] io_avail;
    wire [7:0] dig_in;
    wire [7:0] pins_rd;
    wire bit6_io;
    wire bit6_clkout;
    wire bit7_io;
    wire xfer;
    genvar gi;

    pta_cyc_div u_div (
        .hclk(hclk),
        .hresetn(hresetn),
        .cyc_clk_q(cyc_clk)
    );

    // Single-cycle answers, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign xfer = hsel && hready && htrans[1];

    // Oscillator modes that free bits 6 and 7, or drive the cycle clock
    assign bit6_io = (osc_mode_q == `PTA_OSC_RC_IO) || (osc_mode_q == `PTA_OSC_INT_IO) ||
                     (osc_mode_q == `PTA_OSC_EXT_IO);
    assign bit6_clkout = (osc_mode_q == `PTA_OSC_RC_CLKOUT) ||
                         (osc_mode_q == `PTA_OSC_INT_CLKOUT) ||
                         (osc_mode_q == `PTA_OSC_EXT_CLKOUT);
    assign bit7_io = (osc_mode_q == `PTA_OSC_INT_CLKOUT) ||
                     (osc_mode_q == `PTA_OSC_INT_IO);
    assign io_avail = {bit7_io, bit6_io, 6'h3f};

    // Analog select per pin: bit 5 only on the large package
    assign ans_mask = (LARGE_PKG != 0) ? 8'hff : `PTA_ANS_LO_MASK_SMALL;
    assign ans_pin = {2'h0, analog_select_low_q[5:0] & ans_mask[5:0]};
    assign analog_en = ans_pin;
    assign osc_mode = osc_mode_q;

    // Per-pin digital input path and pin read value
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
            assign dig_in[gi] = pin_in[gi] & ~ans_pin[gi] & io_avail[gi];
            assign pins_rd[gi] = dig_in[gi];
        end
    endgenerate

    // Capture and encoder inputs blocked while analog
    assign capture_in = dig_in[4:2];
    assign encoder_index_input = dig_in[2];
    assign encoder_channel_a = dig_in[3];
    assign encoder_channel_b = dig_in[4];

    // Pin drivers; oscillator functions override direction
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_out <= 8'h00;
            pin_oe <= 8'h00;
        end else begin
            pin_out <= port_output_latch_q & io_avail;
            pin_oe <= ~port_direction_q & io_avail;
            if (bit6_clkout) begin
                pin_out[`PTA_BIT6] <= cyc_clk;
                pin_oe[`PTA_BIT6] <= 1'b1;
            end
        end
    end

    // Address phase capture
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 5'h00;
        end else begin
            wr_pend_q <= xfer && hwrite;
            rd_pend_q <= xfer && !hwrite;
            if (xfer) begin
                addr_q <= haddr[4:0];
            end
        end
    end

    // Register writes in the data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_output_latch_q <= `PTA_RST_LATCH;
            port_direction_q <= `PTA_RST_DIR;
            analog_select_low_q <= `PTA_RST_ANS_LO;
            analog_select_high_q <= `PTA_RST_ANS_HI;
            osc_mode_q <= `PTA_RST_OSC;
        end else if (wr_pend_q) begin
            case (addr_q)
                `PTA_OFS_PINS: port_output_latch_q <= hwdata[7:0];
                `PTA_OFS_LATCH: port_output_latch_q <= hwdata[7:0];
                `PTA_OFS_DIR: port_direction_q <= hwdata[7:0];
                `PTA_OFS_ANS_LO: analog_select_low_q <= hwdata[7:0] & ans_mask;
                `PTA_OFS_ANS_HI: analog_select_high_q <= hwdata[0] & (LARGE_PKG != 0);
                `PTA_OFS_OSC_MODE: osc_mode_q <= hwdata[2:0];
                default: ;
            endcase
        end
    end

    // Read data; bits 7 and 6 of the pin, latch and direction reads are zero unless freed
    always @* begin
        hrdata = 32'h0;
        if (rd_pend_q) begin
            case (addr_q)
                `PTA_OFS_PINS: hrdata[7:0] = pins_rd;
                `PTA_OFS_LATCH: hrdata[7:0] = port_output_latch_q & io_avail;
                `PTA_OFS_DIR: hrdata[7:0] = port_direction_q & io_avail;
                `PTA_OFS_ANS_LO: hrdata[7:0] = analog_select_low_q;
                `PTA_OFS_ANS_HI: hrdata[0] = analog_select_high_q;
                `PTA_OFS_OSC_MODE: hrdata[2:0] = osc_mode_q;
                default: hrdata = 32'h0;
            endcase
        end
    end
endmodule // pta_top

/* verif/pta_board.sv */
// Board model: outside circuitry that meets the port pins
`timescale 1ns/10ps
module pta_board (
    input wire [7:0] pin_out,
    input wire [7:0] pin_oe,
    input wire [7:0] ext,
    output wire [7:0] pin_in
);
    // Port drive wins on each pin, the board level shows elsewhere
    assign pin_in = (pin_out & pin_oe) | (ext & ~pin_oe);
endmodule // pta_board

/* verif/pta_top_sva.sv */
// Checker for pin gating, oscillator pins and register reads of the port block
`timescale 1ns/10ps
module pta_top_sva (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hrdata,
    input wire [7:0] pin_in,
    input wire [7:0] pin_out,
    input wire [7:0] pin_oe,
    input wire [7:0] analog_en,
    input wire [2:0] capture_in,
    input wire encoder_index_input,
    input wire encoder_channel_a,
    input wire encoder_channel_b,
    input wire [2:0] osc_mode
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    reg rv_q;
    reg [5:0] ra_q;
    wire ck6 = osc_mode == 3'h1 || osc_mode == 3'h3 || osc_mode == 3'h5;
    wire io7 = osc_mode == 3'h3 || osc_mode == 3'h4;
    wire io6 = osc_mode == 3'h2 || osc_mode == 3'h4 || osc_mode == 3'h6;
    wire [2:0] gated = pin_in[4:2] & ~analog_en[4:2];
    // Track a read in its data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rv_q <= 1'b0;
            ra_q <= 6'h0;
        end else begin
            rv_q <= hsel && hready && htrans[1] && !hwrite;
            ra_q <= haddr[5:0];
        end
    end
    cap_gate_a: assert property (capture_in == gated) else $error("capture gate");
    enc_gate_a: assert property ({encoder_channel_b, encoder_channel_a,
        encoder_index_input} == gated) else $error("encoder gate");
    ans_reset_a: assert property ($rose(hresetn) |-> analog_en == 8'h3f)
        else $error("analog reset");
    cyc_clk_a: assert property (ck6 [*4] |-> pin_oe[6] && pin_out[6] != $past(pin_out[6], 2))
        else $error("cycle clock");
    bit6_off_a: assert property ((!io6 && !ck6) [*2] |-> !pin_oe[6])
        else $error("bit 6 driven");
    bit7_off_a: assert property ((!io7) [*2] |-> !pin_oe[7]) else $error("bit 7 driven");
    pin_read_a: assert property (rv_q && ra_q == 6'h0 |-> (hrdata[7:0] & analog_en) == 8'h0
        && hrdata[31:8] == 24'h0) else $error("analog pin read");
    top_bits_a: assert property (rv_q && ra_q < 6'hc |-> (hrdata[7:6] & ~{io7, io6}) == 2'b0)
        else $error("top bits read");
    ans_hi_a: assert property (rv_q && ra_q == 6'h10 |-> hrdata[31:1] == 31'h0)
        else $error("analog high read");
    cover property (ck6 [*4]);
    cover property (io7 && io6 && rv_q && ra_q == 6'h0);
    cover property (analog_en == 8'h0 && gated != 3'h0);
endmodule // pta_top_sva
bind pta_top pta_top_sva chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
    .pin_in, .pin_out, .pin_oe, .analog_en, .capture_in, .encoder_index_input,
    .encoder_channel_a, .encoder_channel_b, .osc_mode);

/* verif/pta_top_tb.sv */
// Testbench for the port block: registers, pin drive and oscillator gating
`timescale 1ns/10ps
module pta_top_tb;
    reg hclk, hresetn, hsel, hwrite;
    reg [1:0] htrans;
    reg [31:0] haddr, hwdata, r;
    reg [7:0] ext, lat, dir, ans, e;
    reg [31:0] rv [7] = '{32'h0, 32'h0, 32'h3f, 32'h3f, 32'h1, 32'h0, 32'h0};
    wire hreadyout;
    wire [31:0] hrdata;
    wire [7:0] pin_in, pin_out, pin_oe;
    int fails, total_checks, m;
    pta_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp(), .hrdata, .pin_in, .pin_out, .pin_oe,
        .analog_en(), .capture_in(), .encoder_index_input(), .encoder_channel_a(),
        .encoder_channel_b(), .osc_mode());
    pta_board brd (.pin_out, .pin_oe, .ext, .pin_in);
    // Clock, 10 ns period
    initial begin
        hclk = 0;
        forever #5 hclk = ~hclk;
    end
    // Single word transfer: address phase, then data phase
    task automatic xf(input w, input [7:0] a, input [31:0] d, output [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task ck(input [31:0] g, input [31:0] x);
        total_checks++;
        if (g !== x) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, g, x);
        end
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Pins freed for general use by an oscillator mode
    function [7:0] fr(input [2:0] md);
        fr = {md == 3'h3 || md == 3'h4, md == 3'h2 || md == 3'h4 || md == 3'h6, 6'h3f};
    endfunction
    // Watchdog
    initial begin
        #300000;
        fails++;
        end_sim;
    end
    // Main sequence
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata, ext} = 0;
        void'($urandom(32'hc110));
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (m = 0; m < 7; m++) begin
            xf(0, 8'(m * 4), 0, r);
            ck(r, rv[m]);
        end
        xf(1, 8'h10, 32'hff, r);
        xf(0, 8'h10, 0, r);
        ck(r, 32'h1);
        $display("reset test done");
        xf(1, 8'h14, 32'h4, r);
        repeat (16) begin
            lat = 8'($urandom);
            ans = 8'($urandom) & 8'h3f;
            dir = 8'($urandom) | ans;
            ext <= 8'($urandom);
            xf(1, {5'h0, lat[0], 2'b0}, lat, r);
            xf(1, 8'h08, dir, r);
            xf(1, 8'h0c, ans, r);
            xf(0, 8'h04, 0, r);
            ck(r, lat);
            ck(pin_oe, 8'(~dir));
            ck(pin_out & ~dir, lat & ~dir);
            xf(0, 8'h00, 0, r);
            ck(r, ((lat & ~dir) | (ext & dir)) & ~ans);
        end
        $display("random port test done");
        xf(1, 8'h0c, 0, r);
        xf(1, 8'h08, 0, r);
        xf(1, 8'h04, 32'hff, r);
        for (m = 0; m < 8; m++) begin
            xf(1, 8'h14, m, r);
            repeat (8) @(posedge hclk);
            e = fr(m[2:0]);
            ck(pin_oe[7:6], e[7:6] | {1'b0, m[0] && m != 7});
            xf(0, 8'h04, 0, r);
            ck(r, e);
        end
        $display("oscillator test done");
        end_sim;
    end
endmodule // pta_top_tb
